// ===== shared/jtag_tap_defs.svh
// Constants for the test access port: opcodes, register lengths, buffer depth.
// Assumes inclusion by bare name from the design files and the testbench.
`ifndef JTAG_TAP_DEFS_SVH
`define JTAG_TAP_DEFS_SVH

`define IR_LEN        5
`define ID_LEN        32
`define CFG_LEN       32
`define IR_CAPTURE    5'h01
`define OP_CFG_OUT    5'h04
`define OP_CFG_IN     5'h05
`define OP_IDCODE     5'h09
`define OP_BYPASS     5'h1f
`define OP_DEFAULT    5'h09
`define RESET_ONES    5
`define BUF_DEPTH     2
// Arbitrary neutral identification value
`define ID_VALUE      32'h10000001
`define READ_IDX_W    1

`endif

// ===== shared/jtag_tap_pkg.sv
// Types for the test access port.
// Assumes nothing beyond a SystemVerilog compiler.
package jtag_tap_pkg;
  typedef enum logic [3:0] {
    TestLogicReset, RunTestIdle, SelectDr, CaptureDr, ShiftDr, Exit1Dr,
    PauseDr, Exit2Dr, UpdateDr, SelectIr, CaptureIr, ShiftIr, Exit1Ir,
    PauseIr, Exit2Ir, UpdateIr
  } tap_state_e;
endpackage : jtag_tap_pkg

// ===== hdl/pin_sync.sv
// Two-flop synchroniser for the pin inputs.
// Assumes inputs are asynchronous to mclk.
module pin_sync (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;

  // Reset to one: undriven pins read high
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      meta_q <= 1'b1;
      dout   <= 1'b1;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : pin_sync

// ===== hdl/word_buffer.sv
// Two-entry buffer for configuration words leaving the port.
// Assumes both sides run on mclk.
`include "jtag_tap_defs.svh"

module word_buffer (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [31:0] inData,
  input  wire logic        inValid,
  output logic             inReady,
  output logic [31:0]      outData,
  output logic             outValid,
  input  wire logic        outReady
);
  logic [31:0] mem_q [`BUF_DEPTH];
  logic [`READ_IDX_W-1:0] wrIdx_q;
  logic [`READ_IDX_W-1:0] rdIdx_q;
  logic [1:0]             count_q;
  logic                   push;
  logic                   pop;

  assign inReady = (count_q != 2'(`BUF_DEPTH));
  assign push    = inValid && inReady;
  assign pop     = outValid && outReady;
  assign outValid = (count_q != 2'h0);
  assign outData  = mem_q[rdIdx_q];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wrIdx_q] <= inData;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wrIdx_q <= '0;
      rdIdx_q <= '0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        wrIdx_q <= wrIdx_q + 1'b1;
      end
      if (pop) begin
        rdIdx_q <= rdIdx_q + 1'b1;
      end
      count_q <= 2'(count_q + {1'b0, push} - {1'b0, pop});
    end
  end
endmodule : word_buffer

// ===== hdl/jtag_tap_controller.sv
// Boundary-scan test access port: state machine, instruction register,
// bypass, identification and configuration data registers.
// Assumes tck, tms, tdi are pins sampled by mclk; tck is far slower than mclk.
// What this block does
// - A sixteen-state controller steps on the mode-select level at each rising test-clock edge.
// - Serial input is sampled at the rising test-clock edge while shifting.
// - Serial output changes only at the falling test-clock edge.
// - Serial output is released (high impedance) unless bits are being shifted.
// - Incoming bits go to the one register picked by state and instruction.
// - The instruction or selected data register drives the output by state and instruction.
// - With no reset pin, only the mode-select input returns the controller to reset.
// - An undriven mode-select input reads high.
// - An undriven serial input reads high.
// - The default-high inputs do not depend on any configuration mode.
// - Separate instruction and data shift sequences are entered by distinct patterns.
// - A 32-bit identification register and a configuration register are reachable.
// - The instruction register is five bits wide and takes a full opcode.
// - 00101 loads configuration, 00100 reads back, all ones selects bypass.
`include "jtag_tap_defs.svh"

module jtag_tap_controller (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        tck,
  input  wire logic        tmsIn,
  input  wire logic        tdiIn,
  output logic             tdoOut,
  output logic             tdoOe_n,
  output logic [31:0]      cfgData,
  output logic             cfgValid,
  input  wire logic        cfgReady,
  input  wire logic [31:0] readbackData,
  output logic             readbackStrobe,
  output logic             testMode,
  output logic [3:0]       tapState
);
  jtag_tap_pkg::tap_state_e state_q;
  jtag_tap_pkg::tap_state_e state_d;

  logic tckSync;
  logic tmsSync;
  logic tdiSync;
  logic tckPrev_q;
  logic tckRise;
  logic tckFall;

  logic [`IR_LEN-1:0]  irShift_q;
  logic [`IR_LEN-1:0]  ir_q;
  logic                bypass_q;
  logic [`ID_LEN-1:0]  idShift_q;
  logic [`CFG_LEN-1:0] cfgShift_q;
  logic [5:0]          cfgCount_q;
  logic                serialOut;
  logic                shiftActive;
  logic                wordValid_q;
  logic                bufReady;
  logic [31:0]         bufData;
  logic                bufValid;
  logic                bufPop;

  // Pins pass two flops; reset value one models the pull-ups
  // Pull-up model is unconditional, no mode input exists
  pin_sync syncTck (.mclk(mclk), .reset_n(reset_n), .din(tck),
                    .dout(tckSync));
  pin_sync syncTms (.mclk(mclk), .reset_n(reset_n), .din(tmsIn),
                    .dout(tmsSync));
  pin_sync syncTdi (.mclk(mclk), .reset_n(reset_n), .din(tdiIn),
                    .dout(tdiSync));

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      // Matches the sync flops' reset level, so no false rise follows reset
      tckPrev_q <= 1'b1;
    end else begin
      tckPrev_q <= tckSync;
    end
  end

  assign tckRise = tckSync && !tckPrev_q;
  assign tckFall = !tckSync && tckPrev_q;

  function automatic logic isDataOp(input logic [`IR_LEN-1:0] op,
                                    input logic [`IR_LEN-1:0] want);
    isDataOp = (op == want);
  endfunction : isDataOp

  // Standard state graph; five high edges reach reset from anywhere
  always_comb begin
    state_d = state_q;
    case (state_q)
      jtag_tap_pkg::TestLogicReset: state_d = tmsSync ?
        jtag_tap_pkg::TestLogicReset : jtag_tap_pkg::RunTestIdle;
      jtag_tap_pkg::RunTestIdle: state_d = tmsSync ?
        jtag_tap_pkg::SelectDr : jtag_tap_pkg::RunTestIdle;
      jtag_tap_pkg::SelectDr: state_d = tmsSync ?
        jtag_tap_pkg::SelectIr : jtag_tap_pkg::CaptureDr;
      jtag_tap_pkg::CaptureDr: state_d = tmsSync ?
        jtag_tap_pkg::Exit1Dr : jtag_tap_pkg::ShiftDr;
      jtag_tap_pkg::ShiftDr: state_d = tmsSync ?
        jtag_tap_pkg::Exit1Dr : jtag_tap_pkg::ShiftDr;
      jtag_tap_pkg::Exit1Dr: state_d = tmsSync ?
        jtag_tap_pkg::UpdateDr : jtag_tap_pkg::PauseDr;
      jtag_tap_pkg::PauseDr: state_d = tmsSync ?
        jtag_tap_pkg::Exit2Dr : jtag_tap_pkg::PauseDr;
      jtag_tap_pkg::Exit2Dr: state_d = tmsSync ?
        jtag_tap_pkg::UpdateDr : jtag_tap_pkg::ShiftDr;
      jtag_tap_pkg::UpdateDr: state_d = tmsSync ?
        jtag_tap_pkg::SelectDr : jtag_tap_pkg::RunTestIdle;
      jtag_tap_pkg::SelectIr: state_d = tmsSync ?
        jtag_tap_pkg::TestLogicReset : jtag_tap_pkg::CaptureIr;
      jtag_tap_pkg::CaptureIr: state_d = tmsSync ?
        jtag_tap_pkg::Exit1Ir : jtag_tap_pkg::ShiftIr;
      jtag_tap_pkg::ShiftIr: state_d = tmsSync ?
        jtag_tap_pkg::Exit1Ir : jtag_tap_pkg::ShiftIr;
      jtag_tap_pkg::Exit1Ir: state_d = tmsSync ?
        jtag_tap_pkg::UpdateIr : jtag_tap_pkg::PauseIr;
      jtag_tap_pkg::PauseIr: state_d = tmsSync ?
        jtag_tap_pkg::Exit2Ir : jtag_tap_pkg::PauseIr;
      jtag_tap_pkg::Exit2Ir: state_d = tmsSync ?
        jtag_tap_pkg::UpdateIr : jtag_tap_pkg::ShiftIr;
      jtag_tap_pkg::UpdateIr: state_d = tmsSync ?
        jtag_tap_pkg::SelectDr : jtag_tap_pkg::RunTestIdle;
      default: state_d = jtag_tap_pkg::TestLogicReset;
    endcase
  end

  // Steps only on a rising test-clock edge
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q <= jtag_tap_pkg::TestLogicReset;
    end else if (tckRise) begin
      state_q <= state_d;
    end
  end

  // Instruction shift and update; full five-bit opcode
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irShift_q <= `IR_CAPTURE;
      ir_q      <= `OP_DEFAULT;
    end else if (tckRise) begin
      case (state_q)
        jtag_tap_pkg::CaptureIr: irShift_q <= `IR_CAPTURE;
        jtag_tap_pkg::ShiftIr:
          irShift_q <= {tdiSync, irShift_q[`IR_LEN-1:1]};
        jtag_tap_pkg::UpdateIr: ir_q <= irShift_q;
        default: ir_q <= ir_q;
      endcase
      // After the case so that entering reset always wins
      if (state_d == jtag_tap_pkg::TestLogicReset) begin
        ir_q <= `OP_DEFAULT;
      end
    end
  end

  // Data registers; only the one the instruction picks shifts
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bypass_q  <= 1'b0;
      idShift_q <= `ID_VALUE;
      cfgShift_q <= '0;
    end else if (tckRise) begin
      if (state_q == jtag_tap_pkg::CaptureDr) begin
        bypass_q  <= 1'b0;
        idShift_q <= `ID_VALUE;
        if (isDataOp(ir_q, `OP_CFG_OUT)) begin
          cfgShift_q <= readbackData;
        end
      end else if (state_q == jtag_tap_pkg::ShiftDr) begin
        if (isDataOp(ir_q, `OP_IDCODE)) begin
          idShift_q <= {tdiSync, idShift_q[`ID_LEN-1:1]};
        end else if (isDataOp(ir_q, `OP_CFG_IN) ||
                     isDataOp(ir_q, `OP_CFG_OUT)) begin
          cfgShift_q <= {tdiSync, cfgShift_q[`CFG_LEN-1:1]};
        end else begin
          bypass_q <= tdiSync;
        end
      end
    end
  end

  // Shifted configuration words count to 32 and are offered to the buffer
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cfgCount_q  <= 6'h00;
      wordValid_q <= 1'b0;
    end else begin
      if (wordValid_q && bufReady) begin
        wordValid_q <= 1'b0;
      end
      if (tckRise && state_q == jtag_tap_pkg::CaptureDr) begin
        cfgCount_q <= 6'h00;
      end else if (tckRise && state_q == jtag_tap_pkg::ShiftDr &&
                   isDataOp(ir_q, `OP_CFG_IN)) begin
        if (cfgCount_q == 6'(`CFG_LEN - 1)) begin
          cfgCount_q  <= 6'h00;
          wordValid_q <= 1'b1;
        end else begin
          cfgCount_q <= cfgCount_q + 6'h01;
        end
      end
    end
  end

  // Word copy taken with the 32nd bit; the link has no back-pressure, so
  // a word still waiting when the next completes is overwritten
  logic [31:0] wordHold_q;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wordHold_q <= 32'h00000000;
    end else if (tckRise && state_q == jtag_tap_pkg::ShiftDr &&
                 cfgCount_q == 6'(`CFG_LEN - 1)) begin
      wordHold_q <= {tdiSync, cfgShift_q[`CFG_LEN-1:1]};
    end
  end

  word_buffer cfgBuf (
    .mclk    (mclk),
    .reset_n (reset_n),
    .inData  (wordHold_q),
    .inValid (wordValid_q),
    .inReady (bufReady),
    .outData (bufData),
    .outValid(bufValid),
    .outReady(bufPop)
  );

  // Pop exactly when the output register takes the word, never twice
  assign bufPop = !cfgValid || cfgReady;

  // Output selection by state and instruction
  always_comb begin
    if (state_q == jtag_tap_pkg::ShiftIr) begin
      serialOut = irShift_q[0];
    end else if (isDataOp(ir_q, `OP_IDCODE)) begin
      serialOut = idShift_q[0];
    end else if (isDataOp(ir_q, `OP_CFG_IN) ||
                 isDataOp(ir_q, `OP_CFG_OUT)) begin
      serialOut = cfgShift_q[0];
    end else begin
      serialOut = bypass_q;
    end
  end

  assign shiftActive = (state_q == jtag_tap_pkg::ShiftIr) ||
                       (state_q == jtag_tap_pkg::ShiftDr);

  // Output changes on falling edges only, enabled only while shifting
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tdoOut  <= 1'b1;
      tdoOe_n <= 1'b1;
    end else if (tckFall) begin
      tdoOut  <= serialOut;
      tdoOe_n <= !shiftActive;
    end
  end

  // Registered outputs to the rest of the device
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cfgData        <= 32'h00000000;
      cfgValid       <= 1'b0;
      readbackStrobe <= 1'b0;
      testMode       <= 1'b0;
      tapState       <= 4'h0;
    end else begin
      if (!cfgValid || cfgReady) begin
        cfgValid <= bufValid;
        cfgData  <= bufData;
      end
      readbackStrobe <= tckRise && state_q == jtag_tap_pkg::CaptureDr &&
                        isDataOp(ir_q, `OP_CFG_OUT);
      testMode <= state_q != jtag_tap_pkg::TestLogicReset;
      tapState <= state_q;
    end
  end
endmodule : jtag_tap_controller

// ===== tb/jtag_tap_props.sv
// Checker for the test access port, bound to its top module.
// Assumes tck is slow against mclk and is synchronised inside the port.
module jtag_tap_props (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        tck,
  input wire logic        tmsIn,
  input wire logic        tdiIn,
  input wire logic        tdoOut,
  input wire logic        tdoOe_n,
  input wire logic [31:0] cfgData,
  input wire logic        cfgValid,
  input wire logic        cfgReady,
  input wire logic [31:0] readbackData,
  input wire logic        readbackStrobe,
  input wire logic        testMode,
  input wire logic [3:0]  tapState
);
  logic [2:0] tckS_q;
  logic [2:0] ones_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge mclk) begin
    tckS_q <= !reset_n ? 3'h7 : {tckS_q[1:0], tck};
  end
  // Counts test-clock rises with mode-select high, saturating at five
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ones_q <= 3'h0;
    end else if (tckS_q[1] && !tckS_q[2]) begin
      ones_q <= !tmsIn ? 3'h0 : (ones_q == 3'h5 ? 3'h5 : ones_q + 3'h1);
    end
  end
  a_tdo_on_fall: assert property ($changed(tdoOut) |-> !tck && !$past(tck, 2))
    else $error("serial output moved outside a test-clock fall");
  a_oe_on_fall: assert property ($changed(tdoOe_n) |-> !tck && !$past(tck, 2))
    else $error("output enable moved outside a test-clock fall");
  a_oe_only_shift: assert property (!tdoOe_n |-> tapState inside {4'h4, 4'h5, 4'hb, 4'hc})
    else $error("serial output driven outside shifting");
  a_state_on_rise: assert property ($changed(tapState) |-> $past(tck, 2) && $past(tck, 3))
    else $error("state moved without a test-clock rise");
  a_five_ones: assert property (ones_q == 3'h5 |-> ##[0:3] tapState == 4'h0)
    else $error("five high mode-select rises did not reach reset");
  a_mode_follows: assert property (tapState != 4'h0 |-> ##[0:1] testMode)
    else $error("test mode low outside reset state");
  a_strobe_pulse: assert property (readbackStrobe |=> !readbackStrobe)
    else $error("readback strobe longer than one cycle");
  a_strobe_state: assert property (readbackStrobe |-> tapState inside {4'h3, 4'h4})
    else $error("readback strobe outside capture");
  a_word_hold: assert property (cfgValid && !cfgReady |=> cfgValid && $stable(cfgData))
    else $error("configuration word lost during a stall");
  c_word: cover property (cfgValid && cfgReady);
  c_strobe: cover property (readbackStrobe);
  c_reset: cover property (ones_q == 3'h5);
endmodule : jtag_tap_props

bind jtag_tap_controller jtag_tap_props u_props (.mclk, .reset_n, .tck,
  .tmsIn, .tdiIn, .tdoOut, .tdoOe_n, .cfgData, .cfgValid, .cfgReady,
  .readbackData, .readbackStrobe, .testMode, .tapState);

// ===== tb/jtag_host.sv
// Behavioural boundary-scan host driving the test pins.
// Assumes mclk is the bench clock; pins move 2 ns after its rising edge.
module jtag_host (
  input wire logic mclk,
  input wire logic tdo,
  output logic     tck,
  output logic     tms,
  output logic     tdi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // One test-clock period: low 4 mclk, high 4 mclk; tdo taken before rise
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge mclk);
    #2 tms = m;
    tdi = d;
    repeat (3) @(posedge mclk);
    #2 q = tdo;
    tck = 1'b1;
    repeat (4) @(posedge mclk);
    #2 tck = 1'b0;
  endtask : step
  task automatic walk(input logic [7:0] p, input int n);
    logic q;
    for (int i = 0; i < n; i++) step(p[i], 1'b1, q);
  endtask : walk
  // No reset pin: five high mode-select rises reach reset from anywhere
  task automatic reset_tap();
    walk(8'h1f, 5);
  endtask : reset_tap
  // From idle: shift n bits of d (LSB first) through IR or DR, back to idle
  task automatic scan(input logic ir, input int n, input logic [63:0] d,
                      output logic [63:0] q);
    logic b;
    q = '0;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i], b);
      q[i] = b;
    end
    walk(8'h01, 2);
    tdi = 1'b1;
  endtask : scan
endmodule : jtag_host

// ===== tb/testbench.sv
// Self-checking bench for the test access port with a host model.
// Assumes the host model owns the test pins; the bench is the word sink.
`include "jtag_tap_defs.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
  $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, reset_n, tck, tms, tdi, tdoOut, tdoOe_n;
  logic        cfgValid, cfgReady, readbackStrobe, testMode;
  logic [31:0] cfgData, readbackData;
  logic [3:0]  tapState;
  logic [63:0] d, q;
  logic [31:0] words[$];
  int          failures, checks;
  wire logic   tdoPin = tdoOe_n ? 1'bz : tdoOut;
  jtag_host host (.mclk(mclk), .tdo(tdoPin), .tck(tck), .tms(tms), .tdi(tdi));
  jtag_tap_controller dut (.mclk(mclk), .reset_n(reset_n), .tck(tck),
    .tmsIn(tms), .tdiIn(tdi), .tdoOut(tdoOut), .tdoOe_n(tdoOe_n),
    .cfgData(cfgData), .cfgValid(cfgValid), .cfgReady(cfgReady),
    .readbackData(readbackData), .readbackStrobe(readbackStrobe),
    .testMode(testMode), .tapState(tapState));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (cfgValid === 1'b1 && cfgReady === 1'b1) words.push_back(cfgData);
  end
  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    final_report();
  end
  initial begin
    reset_n = 1'b0;
    cfgReady = 1'b0;
    readbackData = 32'h0;
    void'($urandom(32'h8566736e));
    repeat (16) @(posedge mclk);
    #2 reset_n = 1'b1;
    repeat (3) @(posedge mclk);
    #2;
    `CHK(tapState, 4'h0)
    `CHK(tdoOe_n, 1'b1)
    host.walk(8'($urandom), 8);
    host.reset_tap();
    repeat (6) @(posedge mclk);
    #2;
    `CHK(tapState, 4'h0)
    `CHK(testMode, 1'b0)
    host.walk(8'h00, 1);
    host.scan(1'b0, 32, 64'h0, q);
    `CHK(q[31:0], `ID_VALUE)
    // Bypass and an unknown opcode: one-bit delay, zero captured first
    for (int i = 0; i < 2; i++) begin
      host.scan(1'b1, 5, (i != 0) ? 64'h13 : 64'h1f, q);
      `CHK(q[4:0], `IR_CAPTURE)
      d = {$urandom, $urandom};
      host.scan(1'b0, 32, d, q);
      `CHK(q[31:0], {d[30:0], 1'b0})
    end
    host.scan(1'b1, 5, 64'(`OP_IDCODE), q);
    host.scan(1'b0, 32, {$urandom, $urandom}, q);
    `CHK(q[31:0], `ID_VALUE)
    @(posedge mclk);
    #2 readbackData = $urandom;
    host.scan(1'b1, 5, 64'(`OP_CFG_OUT), q);
    host.scan(1'b0, 32, 64'h0, q);
    `CHK(q[31:0], readbackData)
    `CHK(cfgValid, 1'b0)
    // Two words shifted while the sink stalls, then drained in order
    host.scan(1'b1, 5, 64'(`OP_CFG_IN), q);
    d = {$urandom, $urandom};
    host.scan(1'b0, 64, d, q);
    `CHK(tdoOe_n, 1'b1)
    `CHK(cfgValid, 1'b1)
    #2 cfgReady = 1'b1;
    for (int i = 0; i < 200 && words.size() < 2; i++) @(posedge mclk);
    if (words.size() < 2) begin
      failures++;
    end else begin
      `CHK(words[0], d[31:0])
      `CHK(words[1], d[63:32])
    end
    final_report();
  end
endmodule : testbench
